// file: cst_tx.sv
// transmit path of a clock synchronous serial channel
// assumes pin inputs already synchronous to clock; software controls
// arrive as plain levels and the buffer write as a valid/ready pair
`timescale 1ns/1ps
`include "cst_map.svh"
module cst_tx #(
  parameter int CHANNEL = 1,
  parameter int DEPTH   = `CST_FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              tx_enable,
  input  wire logic              wr_valid,
  input  wire logic [7:0]        wr_data,
  output logic                   wr_ready,
  input  wire logic              clk_src_ext,
  input  wire cst_pkg::cst_div_sel_t clk_div_sel,
  input  wire logic              permit_enable,
  input  wire logic              transmit_permit_input,
  input  wire logic              clk_polarity,
  input  wire logic              msb_first,
  input  wire logic              int_on_complete,
  input  wire logic              multi_pin_enable,
  input  wire logic [1:0]        clk_pin_sel,
  input  wire logic              transfer_clock_pin_in,
  output logic                   transfer_clock_pin_out,
  output logic                   transfer_clock_pin_oe,
  output logic                   alternate_clock_out_pin,
  output logic                   serial_data_out,
  output logic                   shift_register_empty_flag,
  output logic                   tx_irq_req,
  output logic                   handshake_unavailable
);
  import cst_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [5:0] div_of(input cst_div_sel_t s);
    if (s == `CST_SEL_F8) begin
      div_of = `CST_DIV_F8;
    end else if (s == `CST_SEL_F32) begin
      div_of = `CST_DIV_F32;
    end else begin
      div_of = `CST_DIV_F1;
    end
  endfunction

  function automatic logic first_bit(input logic [7:0] b,
                                     input logic msb);
    first_bit = msb ? b[7] : b[0];
  endfunction

  // ------------------------------------------------------------
  // transmit buffer
  // ------------------------------------------------------------
  logic       buf_valid;
  logic [7:0] buf_data;
  logic       buf_pop;

  cst_fifo #(
    .W (`CST_BYTE_W),
    .D (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic mp_active;
  logic permit_ok;
  logic ready_to_send;

  // multi pin only on its channel with the internal clock
  assign mp_active = multi_pin_enable && (CHANNEL == `CST_MP_CHANNEL)
                     && !clk_src_ext;
  assign handshake_unavailable = mp_active;
  // permit gating is dropped in multi pin mode
  assign permit_ok = !permit_enable || mp_active ||
                     !transmit_permit_input;
  assign ready_to_send = tx_enable && buf_valid && permit_ok;

  // ------------------------------------------------------------
  // internal clock divider
  // ------------------------------------------------------------
  logic [5:0] div_cnt_ff;
  logic       tick;

  assign tick = (div_cnt_ff >= div_of(clk_div_sel) - 6'h01);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_ff <= 6'h00;
    end else if (tick) begin
      div_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end

  // ------------------------------------------------------------
  // edge events
  // ------------------------------------------------------------
  // sck_ff is the internal clock in idle-is-one form
  cst_state_t state_ff;
  logic       sck_ff;
  logic       ext_prev_ff;
  logic       ext_lvl;
  logic       lead;
  logic       trail;
  logic       busy;
  logic       reload_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shreg_ff;
  logic       load;
  logic       finish;
  logic       cont;

  assign busy = (state_ff == CST_SHIFT);
  // polarity folds the pin into idle-is-one form
  assign ext_lvl = transfer_clock_pin_in ^ clk_polarity;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev_ff <= 1'b1;
    end else begin
      ext_prev_ff <= ext_lvl;
    end
  end

  // lead edge changes data, trail edge is where the far end samples
  always_comb begin
    if (clk_src_ext) begin
      lead  = ext_prev_ff && !ext_lvl;
      trail = !ext_prev_ff && ext_lvl;
    end else begin
      lead  = tick && sck_ff && (busy || ready_to_send);
      trail = tick && !sck_ff;
    end
  end

  assign load   = lead && ((!busy && ready_to_send) ||
                           (busy && reload_ff));
  assign cont   = tx_enable && buf_valid && permit_ok;
  assign finish = trail && busy && (bit_cnt_ff == `CST_LAST_BIT) &&
                  !cont;
  assign buf_pop = load;

  // ------------------------------------------------------------
  // internal transfer clock
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sck_ff <= 1'b1;
    end else if (clk_src_ext) begin
      sck_ff <= 1'b1;
    end else if (lead) begin
      sck_ff <= 1'b0;
    end else if (trail) begin
      sck_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= CST_IDLE;
    end else begin
      case (state_ff)
        CST_IDLE: begin
          if (load) begin
            state_ff <= CST_SHIFT;
          end
        end
        CST_SHIFT: begin
          if (finish) begin
            state_ff <= CST_IDLE;
          end
        end
        default: begin
          state_ff <= CST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reload_ff <= 1'b0;
    end else if (load) begin
      reload_ff <= 1'b0;
    end else if (trail && busy && bit_cnt_ff == `CST_LAST_BIT) begin
      reload_ff <= cont;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_ff <= 3'h0;
    end else if (load) begin
      bit_cnt_ff <= 3'h0;
    end else if (lead && busy) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // ------------------------------------------------------------
  // shifter and data pin
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shreg_ff <= 8'h00;
    end else if (load) begin
      shreg_ff <= buf_data;
    end else if (lead && busy) begin
      shreg_ff <= msb_first ? {shreg_ff[6:0], 1'b0}
                            : {1'b0, shreg_ff[7:1]};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_out <= 1'b1;
    end else if (load) begin
      serial_data_out <= first_bit(buf_data, msb_first);
    end else if (lead && busy) begin
      serial_data_out <= msb_first ? shreg_ff[6]
                                   : shreg_ff[1];
    end
  end

  // ------------------------------------------------------------
  // status and interrupt request
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_register_empty_flag <= 1'b1;
    end else if (load) begin
      shift_register_empty_flag <= 1'b0;
    end else if (finish) begin
      shift_register_empty_flag <= 1'b1;
    end
  end

  logic byte_done;
  assign byte_done = trail && busy && (bit_cnt_ff == `CST_LAST_BIT);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_irq_req <= 1'b0;
    end else begin
      tx_irq_req <= int_on_complete ? byte_done
                                    : load;
    end
  end

  // ------------------------------------------------------------
  // clock pin routing
  // ------------------------------------------------------------
  logic route_alt_ff;
  logic sck_pin;

  // route only changes while idle, never between chained bytes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      route_alt_ff <= 1'b0;
    end else if (!busy && !load) begin
      route_alt_ff <= mp_active &&
                      (clk_pin_sel == `CST_ROUTE_ALT);
    end
  end

  assign sck_pin = sck_ff ^ clk_polarity;
  // the unused pin is held high, so two receivers share data in turn
  assign transfer_clock_pin_out  = route_alt_ff ? 1'b1 : sck_pin;
  assign transfer_clock_pin_oe   = !clk_src_ext && !route_alt_ff;
  assign alternate_clock_out_pin = route_alt_ff ? sck_pin
                                                : 1'b1;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_load;
    load && !msb_first;
  endsequence

  sequence s_finish;
    finish;
  endsequence

  property p_enable;
    @(posedge clock) disable iff (!rst_b)
      (!busy && !tx_enable) |=> !busy;
  endproperty
  a_enable: assert property (p_enable)
    else $error("transfer started while transmit disabled");

  property p_permit;
    @(posedge clock) disable iff (!rst_b)
      (!busy && permit_enable && !mp_active && transmit_permit_input)
      |=> !busy;
  endproperty
  a_permit: assert property (p_permit)
    else $error("transfer started without permit");

  property p_load_irq;
    @(posedge clock) disable iff (!rst_b)
      (load && !int_on_complete) |=> tx_irq_req && !shift_register_empty_flag;
  endproperty
  a_load_irq: assert property (p_load_irq)
    else $error("no irq or empty flag wrong at load");

  property p_lsb;
    @(posedge clock) disable iff (!rst_b)
      s_load |=> serial_data_out == $past(buf_data[0]);
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("first bit is not the lsb");

  property p_finish;
    @(posedge clock) disable iff (!rst_b)
      s_finish |=> shift_register_empty_flag && sck_ff && !busy;
  endproperty
  a_finish: assert property (p_finish)
    else $error("end of byte not flagged or clock not parked");

  property p_gapless;
    @(posedge clock) disable iff (!rst_b)
      (byte_done && cont) |=> busy && reload_ff;
  endproperty
  a_gapless: assert property (p_gapless)
    else $error("buffered byte not chained");

  property p_done_irq;
    @(posedge clock) disable iff (!rst_b)
      (byte_done && int_on_complete) |=> tx_irq_req;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("no irq at transmission complete");

  property p_route;
    @(posedge clock) disable iff (!rst_b)
      route_alt_ff |-> transfer_clock_pin_out &&
                       alternate_clock_out_pin == sck_pin;
  endproperty
  a_route: assert property (p_route)
    else $error("clock not on alternate pin");

  property p_mp;
    @(posedge clock) disable iff (!rst_b)
      (multi_pin_enable && clk_src_ext) |-> !handshake_unavailable;
  endproperty
  a_mp: assert property (p_mp)
    else $error("multi pin active with external clock");

  property p_count;
    @(posedge clock) disable iff (!rst_b)
      load |=> bit_cnt_ff == 3'h0 && busy;
  endproperty
  a_count: assert property (p_count)
    else $error("bit count not restarted at load");

  property p_idle_high;
    @(posedge clock) disable iff (!rst_b)
      (!busy && !load) |=> sck_ff;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("internal clock active while idle");

endmodule // cst_tx

// file: cst_map.svh
// constants of the clocked serial transmitter
// assumes a 50 MHz system clock and byte-wide transmit data
//
// Behaviour
// - send only once transmit is enabled and a byte is buffered
// - with permit on, start only after the permit input goes low
// - first leading edge loads shifter, drives bit one, may raise irq
// - remaining bits leave lsb or msb first by choice, one per leading clock edge
// - after eight bits set the empty flag and park the clock pin at idle, high with polarity clear and low with it set
// - a byte buffered before the eighth bit follows with no gap
// - clock source is internal divided by 1, 8 or 32, or the pin
// - polarity picks falling or rising edge for data changes
// - multi pin mode ignores permit and starts once enabled with a byte buffered
// - complete selection raises the irq when the last bit ends
// - in multi pin mode both route select bits set move the clock to the alternate pin
// - multi pin only on channel one, internal clock, no handshakes
// - irq on buffer to shifter move or on shifter empty, by choice
// - empty flag reads zero while sending, one once finished
// - two clock pins let one channel serve two receivers in turn
`ifndef CST_MAP_SVH
`define CST_MAP_SVH
`define CST_BYTE_W      8
`define CST_FIFO_DEPTH  16
`define CST_LAST_BIT    3'h7
`define CST_DIV_F1      6'h01
`define CST_DIV_F8      6'h08
`define CST_DIV_F32     6'h20
`define CST_SEL_F1      2'h0
`define CST_SEL_F8      2'h1
`define CST_SEL_F32     2'h2
`define CST_ROUTE_ALT   2'h3
`define CST_MP_CHANNEL  1
`endif

// file: cst_pkg.sv
// types of the clocked serial transmitter
// assumes cst_map.svh is on the include path
package cst_pkg;
  typedef enum logic [0:0] {
    CST_IDLE,
    CST_SHIFT
  } cst_state_t;
  typedef logic [1:0] cst_div_sel_t;
endpackage

// file: cst_fifo.sv
// transmit buffer fifo with valid and ready on both sides
// assumes one clock and an active low asynchronous reset
`timescale 1ns/1ps
module cst_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr_ff;
  logic [AW:0]  rd_ptr_ff;
  logic         full;
  logic         empty;
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                 (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];
  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_ff <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule // cst_fifo

// file: cst_rx_model.sv
// far-side serial receiver model: samples data, drives permit and ext clock
// assumes sck is whichever clock pin the transmitter currently drives
`timescale 1ns/1ps
module cst_rx_model (
  input  wire logic sck,
  input  wire logic sdata,
  input  wire logic clk_pol,
  input  wire logic msb_first,
  output logic      ext_clk,
  output logic      permit_b
);
  logic [7:0] shreg;
  int         nbits;
  logic [7:0] got[$];

  initial begin
    ext_clk  = 1'b1;
    permit_b = 1'b1;
    nbits    = 0;
    shreg    = 8'h00;
  end

  // ----------------------------------------------------------------
  // sampling on the trailing edge, where the clock returns to idle
  // ----------------------------------------------------------------
  always @(sck) begin
    if (sck === ~clk_pol) begin
      shreg = msb_first ? {shreg[6:0], sdata} : {sdata, shreg[7:1]};
      nbits = nbits + 1;
      if (nbits == 8) begin
        got.push_back(shreg);
        nbits = 0;
      end
    end
  end

  task automatic clear(input logic pol);
    ext_clk = ~pol;
    nbits   = 0;
    got.delete();
  endtask

  // permit is the receiving side's to drive
  task automatic set_permit(input logic v);
    permit_b = v;
  endtask

  // external clock runs only for the bits asked, then rests at idle
  task automatic ext_burst(input int n, input int half_ns);
    for (int i = 0; i < n; i++) begin
      #(half_ns) ext_clk = clk_pol;
      #(half_ns) ext_clk = ~clk_pol;
    end
  endtask
endmodule // cst_rx_model

// file: cst_tx_test.sv
// self-checking bench for the clocked serial transmitter
// assumes cst_rx_model as far side and cst_map.svh on the include path
`timescale 1ns/1ps
`include "cst_map.svh"
module cst_tx_test;
  import cst_pkg::*;
  logic         clock = 1'b0, rst_b = 1'b0, tx_enable = 1'b0;
  logic         wr_valid = 1'b0, clk_src_ext = 1'b0, permit_enable = 1'b0;
  logic         clk_polarity = 1'b0, msb_first = 1'b0;
  logic         int_on_complete = 1'b0, multi_pin_enable = 1'b0;
  logic [7:0]   wr_data = 8'h00;
  logic [1:0]   clk_pin_sel = 2'h0;
  cst_div_sel_t clk_div_sel = 2'h0;
  logic         wr_ready, pin_out, pin_oe, alt_pin, sdo, empty, irq, hs_na;
  logic         ext_clk, permit_b, sck, routed;
  int           miscompares = 0, n_checks = 0, irq_cnt = 0;

  always #10 clock = ~clock;
  always @(posedge clock) if (irq === 1'b1) irq_cnt++;
  assign routed = multi_pin_enable && !clk_src_ext &&
                  clk_pin_sel == `CST_ROUTE_ALT;
  assign sck = clk_src_ext ? ext_clk : (routed ? alt_pin : pin_out);

  cst_tx dut_u (
    .clock(clock), .rst_b(rst_b), .tx_enable(tx_enable),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .clk_src_ext(clk_src_ext), .clk_div_sel(clk_div_sel),
    .permit_enable(permit_enable), .transmit_permit_input(permit_b),
    .clk_polarity(clk_polarity), .msb_first(msb_first),
    .int_on_complete(int_on_complete), .multi_pin_enable(multi_pin_enable),
    .clk_pin_sel(clk_pin_sel), .transfer_clock_pin_in(ext_clk),
    .transfer_clock_pin_out(pin_out), .transfer_clock_pin_oe(pin_oe),
    .alternate_clock_out_pin(alt_pin), .serial_data_out(sdo),
    .shift_register_empty_flag(empty), .tx_irq_req(irq),
    .handshake_unavailable(hs_na));

  cst_rx_model partner_u (.sck(sck), .sdata(sdo), .clk_pol(clk_polarity),
    .msb_first(msb_first), .ext_clk(ext_clk), .permit_b(permit_b));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic int div_of(input logic [1:0] s);
    return (s == `CST_SEL_F8) ? `CST_DIV_F8 :
           (s == `CST_SEL_F32) ? `CST_DIV_F32 : `CST_DIV_F1;
  endfunction

  // cycles from the first leading edge to the last trailing edge
  function automatic int span(input int k, input int n);
    return (16 * k - 1) * n;
  endfunction

  // f = {ext, polarity, msb, complete, permit, multi}; only while idle
  task automatic cfg(input logic [1:0] sel, input logic [5:0] f,
                     input logic [1:0] ps);
    {clk_src_ext, clk_polarity, msb_first, int_on_complete,
     permit_enable, multi_pin_enable} = f;
    clk_div_sel = sel;
    clk_pin_sel = ps;
    partner_u.clear(f[4]);
  endtask

  // ----------------------------------------------------------------
  // one burst of k buffered bytes, checked end to end
  // ----------------------------------------------------------------
  task automatic run_burst(input int k);
    logic [7:0] sent[$];
    logic       mp;
    int         cyc, irq0, n;
    mp = multi_pin_enable && !clk_src_ext;
    n  = clk_src_ext ? 5 : div_of(clk_div_sel);
    partner_u.set_permit(1'b1);
    step();
    partner_u.clear(clk_polarity);
    for (int i = 0; i < k; i++) begin
      sent.push_back(8'($urandom));
      wr_data  = sent[i];
      wr_valid = 1'b1;
      step();
    end
    if (k == 16) begin
      check(wr_ready, 1'b0);
      wr_data = 8'h5a;
      step();
    end
    wr_valid = 1'b0;
    step(40);
    check(empty, 1'b1);
    irq0      = irq_cnt;
    tx_enable = 1'b1;
    if (permit_enable && !mp) begin
      step(40);
      check(empty, 1'b1);
    end
    if (!mp) partner_u.set_permit(1'b0);
    if (clk_src_ext) fork partner_u.ext_burst(8 * k, 100); join_none
    cyc = 0;
    while (empty === 1'b1 && cyc < 200) begin
      step();
      cyc++;
    end
    check(sdo, sent[0][msb_first ? 7 : 0]);
    if (!int_on_complete) check(irq, 1'b1);
    check(hs_na, mp);
    check(pin_oe, !clk_src_ext && !routed);
    if (!clk_src_ext) check(routed ? alt_pin : pin_out, clk_polarity);
    cyc = 0;
    while (empty === 1'b0 && cyc < 5000) begin
      step();
      cyc++;
    end
    check(cyc, span(k, n));
    if (int_on_complete) check(irq, 1'b1);
    step(3);
    check(irq_cnt - irq0, k);
    if (!clk_src_ext) check(routed ? alt_pin : pin_out, !clk_polarity);
    check(partner_u.got.size(), k);
    foreach (sent[i]) check(partner_u.got[i], sent[i]);
    tx_enable = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2124));
    repeat (12) @(posedge clock);
    #1 rst_b = 1'b1;
    step();
    check(sdo, 1'b1);
    check(empty, 1'b1);
    check(irq, 1'b0);
    check(pin_out, 1'b1);
    check(alt_pin, 1'b1);
    check(wr_ready, 1'b1);
    cfg(2'h0, 6'b000000, 2'h0);
    run_burst(1);
    cfg(2'h2, 6'b000110, 2'h0);
    run_burst(3);
    cfg(2'h0, 6'b010000, 2'h0);
    run_burst(16);
    cfg(2'h1, 6'b101010, 2'h0);
    run_burst(2);
    cfg(2'h1, 6'b000111, 2'h3);
    run_burst(2);
    repeat (10) begin
      cfg(2'($urandom_range(3)), 6'($urandom), 2'($urandom));
      run_burst($urandom_range(3, 1));
    end
    tally_and_finish();
  end

  initial begin
    #1_000_000;
    miscompares++;
    tally_and_finish();
  end
endmodule // cst_tx_test
